// [src/tic_pkg.sv]
package tic_pkg;

   // direct-access window of the eight cell templates
   localparam logic [10:0] TIC_TPL_BASE     = 11'h500;
   localparam logic [10:0] TIC_TPL_LAST     = 11'h5ff;
   localparam int          TIC_GROUPS       = 8;
   localparam int          TIC_WORDS        = 32;
   localparam int          TIC_RAM_DEPTH    = TIC_GROUPS * TIC_WORDS;
   localparam int          TIC_RAM_AW       = 8;
   localparam int          TIC_DW           = 16;

   // word offsets inside one template
   localparam logic [4:0] TIC_OFS_HDR_1_2      = 5'h00;
   localparam logic [4:0] TIC_OFS_HDR_3_4      = 5'h01;
   localparam logic [4:0] TIC_OFS_HEC_OAM      = 5'h02;
   localparam logic [4:0] TIC_OFS_LINK_SEQ     = 5'h03;
   localparam logic [4:0] TIC_OFS_OFFSET_STUFF = 5'h04;
   localparam logic [4:0] TIC_OFS_CHG_GRP_ID   = 5'h05;
   localparam logic [4:0] TIC_OFS_GSC_SYNC     = 5'h06;
   localparam logic [4:0] TIC_OFS_TEST_CTL     = 5'h07;
   localparam logic [4:0] TIC_OFS_RX_TEST_L0   = 5'h08;
   localparam logic [4:0] TIC_OFS_LINK_STATUS  = 5'h09;
   localparam logic [4:0] TIC_OFS_L31_PAD      = 5'h18;
   localparam logic [4:0] TIC_OFS_E2E_CRC_HI   = 5'h19;
   localparam logic [4:0] TIC_OFS_CRC_LO       = 5'h1a;
   localparam logic [4:0] TIC_OFS_LAST_WORD    = 5'h1f;

   // byte indices in the outgoing cell, 0 is the first header byte
   localparam logic [5:0] TIC_B_HDR_LAST  = 6'h03;
   localparam logic [5:0] TIC_B_HEC       = 6'h04;
   localparam logic [5:0] TIC_B_PAY_FIRST = 6'h05;
   localparam logic [5:0] TIC_B_LINK      = 6'h06;
   localparam logic [5:0] TIC_B_SEQ       = 6'h07;
   localparam logic [5:0] TIC_B_OFFSET    = 6'h08;
   localparam logic [5:0] TIC_B_STUFF     = 6'h09;
   localparam logic [5:0] TIC_B_CHANGE    = 6'h0a;
   localparam logic [5:0] TIC_B_SYNC      = 6'h0d;
   localparam logic [5:0] TIC_B_CRC_LAST  = 6'h32;
   localparam logic [5:0] TIC_B_CRC_HI    = 6'h33;
   localparam logic [5:0] TIC_B_CRC_LO    = 6'h34;

   localparam logic [7:0] TIC_HEC_POLY    = 8'h07;
   localparam logic [7:0] TIC_HEC_COSET   = 8'h55;
   localparam logic [9:0] TIC_CRC10_POLY  = 10'h233;
   localparam logic [7:0] TIC_READY_RST   = 8'hff;

   typedef enum logic [3:0] {
      TIC_TX_IDLE  = 4'b0001,
      TIC_TX_FETCH = 4'b0010,
      TIC_TX_LOAD  = 4'b0100,
      TIC_TX_SEND  = 4'b1000
   } tic_tx_state_e;

   // header check, msb first, no coset
   function automatic logic [7:0] tic_hec_byte(input logic [7:0] c_in,
                                               input logic [7:0] b);
      logic [7:0] c;
      logic       fb;
      c = c_in;
      for (int i = 7; i >= 0; i--)
      begin
         fb = c[7] ^ b[i];
         c  = {c[6:0], 1'b0} ^ (fb ? TIC_HEC_POLY : 8'h00);
      end
      return c;
   endfunction : tic_hec_byte

   // augmented crc-10: feed every payload bit, crc field as zero
   function automatic logic [9:0] tic_crc10_byte(input logic [9:0] c_in,
                                                 input logic [7:0] b);
      logic [9:0] c;
      logic       msb;
      c = c_in;
      for (int i = 7; i >= 0; i--)
      begin
         msb = c[9];
         c   = {c[8:0], b[i]} ^ (msb ? TIC_CRC10_POLY : 10'h000);
      end
      return c;
   endfunction : tic_crc10_byte

endpackage : tic_pkg

// [src/tic_word_ram.sv]
`timescale 1ns/10ps
`default_nettype none

module tic_word_ram
   import tic_pkg::*;
(
   input  wire logic                  sys_clk_i,  // core clock
   input  wire logic                  sys_rst_i,  // async reset
   input  wire logic                  we_i,       // write strobe
   input  wire logic [TIC_RAM_AW-1:0] waddr_i,    // write address
   input  wire logic [TIC_DW-1:0]     wdata_i,    // write data
   input  wire logic                  re_i,       // read strobe
   input  wire logic [TIC_RAM_AW-1:0] raddr_i,    // read address
   output logic      [TIC_DW-1:0]     rdata_o     // registered read data
);

   logic [TIC_DW-1:0] mem [TIC_RAM_DEPTH];

   always_ff @(posedge sys_clk_i)
   begin
      if (we_i)
         mem[waddr_i] <= wdata_i;
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rdata_o <= 16'h0000;
      else if (re_i)
         rdata_o <= mem[raddr_i];
   end

endmodule : tic_word_ram

`default_nettype wire

// [src/tic_cell_builder.sv]
`timescale 1ns/10ps
`default_nettype none

// How it works
// - eight 32-word templates, one per group, at 0x0500 to 0x05FF
// - software writes template, transfer command copies it to cell memory
// - header check byte always computed and inserted, template ignored
// - byte seven: cell id bit and link_identifier inserted by device
// - byte eight carries the current frame sequence number
// - byte nine cell offset and byte ten stuff indication inserted
// - byte eleven change indication inserted, group id byte as written
// - byte fourteen sync info inserted, group status byte as written
// - end-to-end byte from template, crc bits 9:8 into word 19 high
// - crc bits 7:0 go into the last byte, words 1B-1F unused
// - copy completion sets group ready back to one and raises a flag
module tic_cell_builder
   import tic_pkg::*;
(
   input  wire logic        sys_clk_i,       // 50 MHz core clock
   input  wire logic        sys_rst_i,       // async reset, active high
   input  wire logic        cpu_cs_i,        // register port select
   input  wire logic        cpu_wr_i,        // write strobe
   input  wire logic        cpu_rd_i,        // read strobe
   input  wire logic [10:0] cpu_addr_i,      // word address
   input  wire logic [15:0] cpu_wdata_i,     // write data
   output logic      [15:0] cpu_rdata_o,     // read data
   output logic             cpu_rvalid_o,    // read data valid pulse
   input  wire logic        xfer_start_i,    // transfer command pulse
   input  wire logic [2:0]  xfer_group_i,    // group to transfer
   output logic      [7:0]  xfer_ready_o,    // per-group ready
   output logic             xfer_done_o,     // sticky completion flag
   input  wire logic        xfer_done_clr_i, // clears completion flag
   input  wire logic        cell_start_i,    // send one cell
   input  wire logic [2:0]  cell_group_i,    // group of the cell
   input  wire logic        cell_id_i,       // cell id bit
   input  wire logic [4:0]  link_identifier_i, // transmit link id
   input  wire logic [7:0]  frame_seq_i,     // frame sequence number
   input  wire logic [7:0]  cell_offset_i,   // control cell offset
   input  wire logic [7:0]  stuff_ind_i,     // link stuff indication
   input  wire logic [7:0]  change_ind_i,    // status change indication
   input  wire logic [7:0]  sync_info_i,     // sync information
   output logic             cell_busy_o,     // cell in progress
   output logic             tx_valid_o,      // byte valid
   input  wire logic        tx_ready_i,      // byte accepted
   output logic      [7:0]  tx_byte_o,       // cell byte
   output logic             tx_first_o,      // first byte of cell
   output logic             tx_last_o        // last byte of cell
);

   logic                  cpu_hit;
   logic                  tpl_we;
   logic                  cpu_tpl_rd;
   logic                  tpl_re;
   logic [TIC_RAM_AW-1:0] tpl_raddr;
   logic [15:0]           tpl_q;
   logic                  rsel_r;
   logic                  rvalid_r;

   logic                  copy_busy_r;
   logic [2:0]            copy_grp_r;
   logic [4:0]            copy_ra_r;
   logic                  copy_issued_r;
   logic                  copy_pend_r;
   logic [4:0]            copy_wa_r;
   logic                  copy_issue;
   logic                  copy_take;
   logic                  copy_end;
   logic [7:0]            ready_r;
   logic                  done_r;

   tic_tx_state_e         st_r;
   logic [2:0]            tx_grp_r;
   logic [5:0]            idx_r;
   logic [15:0]           word_r;
   logic [7:0]            byte_r;
   logic [7:0]            hec_r;
   logic [9:0]            crc_r;
   logic [7:0]            crc_lo_r;
   logic                  fld_cid_r;
   logic [4:0]            fld_lid_r;
   logic [7:0]            fld_seq_r;
   logic [7:0]            fld_ofs_r;
   logic [7:0]            fld_stf_r;
   logic [7:0]            fld_chg_r;
   logic [7:0]            fld_syn_r;
   logic [15:0]           cell_q;
   logic                  accept;
   logic [9:0]            crc_upd;
   logic [7:0]            hec_upd;
   logic                  form_load;
   logic [5:0]            form_n;
   logic [15:0]           form_w;
   logic [9:0]            form_crc;
   logic [7:0]            form_raw;
   logic [9:0]            crc_full;
   logic [7:0]            form_byte;

   // register port: template window only, other addresses read as zero
   assign cpu_hit    = cpu_cs_i && (cpu_addr_i >= TIC_TPL_BASE)
                       && (cpu_addr_i <= TIC_TPL_LAST);
   assign tpl_we     = cpu_hit && cpu_wr_i;
   assign cpu_tpl_rd = cpu_hit && cpu_rd_i && !cpu_wr_i;

   // copy engine yields the template read port to software reads
   assign copy_issue = copy_busy_r && !copy_issued_r && !cpu_tpl_rd;
   assign tpl_re     = cpu_tpl_rd || copy_issue;
   assign tpl_raddr  = cpu_tpl_rd ? cpu_addr_i[TIC_RAM_AW-1:0]
                                  : {copy_grp_r, copy_ra_r};

   tic_word_ram u_tpl_ram (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .we_i      (tpl_we),
      .waddr_i   (cpu_addr_i[TIC_RAM_AW-1:0]),
      .wdata_i   (cpu_wdata_i),
      .re_i      (tpl_re),
      .raddr_i   (tpl_raddr),
      .rdata_o   (tpl_q)
   );

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rsel_r   <= 1'b0;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rsel_r   <= cpu_tpl_rd;
         rvalid_r <= cpu_cs_i && cpu_rd_i && !cpu_wr_i;
      end
   end

   assign cpu_rdata_o  = rsel_r ? tpl_q : 16'h0000;
   assign cpu_rvalid_o = rvalid_r;

   // transfer command taken only for an idle, ready group
   assign copy_take = xfer_start_i && !copy_busy_r && ready_r[xfer_group_i];
   assign copy_end  = copy_pend_r && (copy_wa_r == TIC_OFS_LAST_WORD);

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         copy_busy_r   <= 1'b0;
         copy_grp_r    <= 3'h0;
         copy_ra_r     <= 5'h00;
         copy_issued_r <= 1'b0;
         copy_pend_r   <= 1'b0;
         copy_wa_r     <= 5'h00;
      end
      else
      begin
         copy_pend_r <= copy_issue;
         if (copy_issue)
         begin
            copy_wa_r <= copy_ra_r;
            copy_ra_r <= copy_ra_r + 5'h01;
            if (copy_ra_r == TIC_OFS_LAST_WORD)
               copy_issued_r <= 1'b1;
         end
         if (copy_take)
         begin
            copy_busy_r   <= 1'b1;
            copy_grp_r    <= xfer_group_i;
            copy_ra_r     <= 5'h00;
            copy_issued_r <= 1'b0;
         end
         else if (copy_end)
            copy_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ready_r <= TIC_READY_RST;
      else
      begin
         if (copy_take)
            ready_r[xfer_group_i] <= 1'b0;
         if (copy_end)
            ready_r[copy_grp_r] <= 1'b1;
      end
   end

   // completion flag: a new completion wins over a clear
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         done_r <= 1'b0;
      else if (copy_end)
         done_r <= 1'b1;
      else if (xfer_done_clr_i)
         done_r <= 1'b0;
   end

   assign xfer_ready_o = ready_r;
   assign xfer_done_o  = done_r;

   tic_word_ram u_cell_ram (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .we_i      (copy_pend_r),
      .waddr_i   ({copy_grp_r, copy_wa_r}),
      .wdata_i   (tpl_q),
      .re_i      (st_r == TIC_TX_FETCH),
      .raddr_i   ({tx_grp_r, idx_r[5:1]}),
      .rdata_o   (cell_q)
   );

   assign accept  = (st_r == TIC_TX_SEND) && tx_ready_i;
   assign hec_upd = (idx_r <= TIC_B_HDR_LAST) ? tic_hec_byte(hec_r, byte_r)
                                             : hec_r;
   assign crc_upd = (idx_r >= TIC_B_PAY_FIRST && idx_r <= TIC_B_CRC_LAST)
                    ? tic_crc10_byte(crc_r, byte_r) : crc_r;

   // next outgoing byte, with device fields substituted on the way out
   assign form_load = (st_r == TIC_TX_LOAD);
   assign form_n    = form_load ? idx_r : idx_r + 6'h01;
   assign form_w    = form_load ? cell_q : word_r;
   assign form_crc  = form_load ? crc_r : crc_upd;
   assign form_raw  = form_n[0] ? form_w[15:8] : form_w[7:0];
   assign crc_full  = tic_crc10_byte(tic_crc10_byte(form_crc,
                         {form_raw[7:2], 2'b00}), 8'h00);

   always_comb
   begin
      case (form_n)
         TIC_B_HEC:    form_byte = hec_r ^ TIC_HEC_COSET;
         TIC_B_LINK:   form_byte = {fld_cid_r, form_raw[6:5],
                                    fld_lid_r};
         TIC_B_SEQ:    form_byte = fld_seq_r;
         TIC_B_OFFSET: form_byte = fld_ofs_r;
         TIC_B_STUFF:  form_byte = fld_stf_r;
         TIC_B_CHANGE: form_byte = fld_chg_r;
         TIC_B_SYNC:   form_byte = fld_syn_r;
         TIC_B_CRC_HI: form_byte = {form_raw[7:2],
                                    crc_full[9:8]};
         TIC_B_CRC_LO: form_byte = crc_lo_r;
         default:      form_byte = form_raw;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         st_r     <= TIC_TX_IDLE;
         tx_grp_r <= 3'h0;
         idx_r    <= 6'h00;
         word_r   <= 16'h0000;
         byte_r   <= 8'h00;
         hec_r    <= 8'h00;
         crc_r    <= 10'h000;
         crc_lo_r <= 8'h00;
      end
      else
      begin
         case (st_r)
            TIC_TX_IDLE:
            begin
               if (cell_start_i)
               begin
                  tx_grp_r <= cell_group_i;
                  idx_r    <= 6'h00;
                  hec_r    <= 8'h00;
                  crc_r    <= 10'h000;
                  st_r     <= TIC_TX_FETCH;
               end
            end
            TIC_TX_FETCH:
               st_r <= TIC_TX_LOAD;
            TIC_TX_LOAD:
            begin
               word_r <= cell_q;
               byte_r <= form_byte;
               st_r   <= TIC_TX_SEND;
            end
            TIC_TX_SEND:
            begin
               if (accept)
               begin
                  hec_r <= hec_upd;
                  crc_r <= crc_upd;
                  idx_r <= idx_r + 6'h01;
                  if (idx_r == TIC_B_CRC_LO)
                     st_r <= TIC_TX_IDLE;
                  else if (idx_r[0])
                     st_r <= TIC_TX_FETCH;
                  else
                  begin
                     byte_r <= form_byte;
                     if (form_n == TIC_B_CRC_HI)
                        crc_lo_r <= crc_full[7:0];
                  end
               end
            end
            default:
               st_r <= TIC_TX_IDLE;
         endcase
      end
   end

   // inserted fields are held for the whole cell
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         fld_cid_r <= 1'b0;
         fld_lid_r <= 5'h00;
         fld_seq_r <= 8'h00;
         fld_ofs_r <= 8'h00;
         fld_stf_r <= 8'h00;
         fld_chg_r <= 8'h00;
         fld_syn_r <= 8'h00;
      end
      else if (st_r == TIC_TX_IDLE && cell_start_i)
      begin
         fld_cid_r <= cell_id_i;
         fld_lid_r <= link_identifier_i;
         fld_seq_r <= frame_seq_i;
         fld_ofs_r <= cell_offset_i;
         fld_stf_r <= stuff_ind_i;
         fld_chg_r <= change_ind_i;
         fld_syn_r <= sync_info_i;
      end
   end

   assign cell_busy_o = (st_r != TIC_TX_IDLE);
   assign tx_valid_o  = (st_r == TIC_TX_SEND);
   assign tx_byte_o   = byte_r;
   assign tx_first_o  = (st_r == TIC_TX_SEND) && (idx_r == 6'h00);
   assign tx_last_o   = (st_r == TIC_TX_SEND) && (idx_r == TIC_B_CRC_LO);

endmodule : tic_cell_builder

`default_nettype wire

// [test/tic_cell_builder_assertions.sv]
`timescale 1ns/10ps
`default_nettype none

module tic_cell_builder_chk
(
   input wire logic        sys_clk_i,       // core clock
   input wire logic        sys_rst_i,       // async reset
   input wire logic        cpu_cs_i,        // port select
   input wire logic        cpu_wr_i,        // write strobe
   input wire logic        cpu_rd_i,        // read strobe
   input wire logic [10:0] cpu_addr_i,      // word address
   input wire logic [15:0] cpu_rdata_o,     // read data
   input wire logic        cpu_rvalid_o,    // read valid
   input wire logic        xfer_start_i,    // copy command
   input wire logic [2:0]  xfer_group_i,    // copy group
   input wire logic [7:0]  xfer_ready_o,    // ready per group
   input wire logic        xfer_done_o,     // done flag
   input wire logic        xfer_done_clr_i, // done clear
   input wire logic        cell_start_i,    // cell request
   input wire logic        cell_busy_o,     // cell busy
   input wire logic        tx_valid_o,      // byte valid
   input wire logic        tx_ready_i,      // byte taken
   input wire logic [7:0]  tx_byte_o,       // cell byte
   input wire logic        tx_first_o,      // first byte
   input wire logic        tx_last_o        // last byte
);
   logic       rd_req;
   logic [6:0] copy_cyc_r;
   logic       rd_in_copy_r;
   logic [5:0] byte_cnt_r;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   assign rd_req = cpu_cs_i && cpu_rd_i && !cpu_wr_i;

   // copy length, only judged when no cpu read stretched it
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         copy_cyc_r   <= 7'h00;
         rd_in_copy_r <= 1'b0;
      end
      else if (xfer_ready_o == 8'hff)
      begin
         copy_cyc_r   <= 7'h00;
         rd_in_copy_r <= 1'b0;
      end
      else
      begin
         copy_cyc_r   <= copy_cyc_r + 7'h01;
         rd_in_copy_r <= rd_in_copy_r || rd_req;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         byte_cnt_r <= 6'h00;
      else if (tx_valid_o && tx_ready_i)
         byte_cnt_r <= tx_first_o ? 6'h01 : byte_cnt_r + 6'h01;
   end

   a_read_answer: assert property (
      rd_req |=> cpu_rvalid_o) else $error("read not answered");
   a_unmapped_zero: assert property (
      rd_req && (cpu_addr_i < 11'h500 || cpu_addr_i > 11'h5ff)
      |=> cpu_rdata_o == 16'h0000) else $error("unmapped read not 0");
   a_copy_start: assert property (
      xfer_start_i && xfer_ready_o == 8'hff
      |=> xfer_ready_o == ~(8'h01 << $past(xfer_group_i)))
      else $error("ready bit did not drop");
   a_copy_length: assert property (
      $rose(&xfer_ready_o) && !rd_in_copy_r |-> copy_cyc_r == 7'h21)
      else $error("copy length wrong");
   a_done_at_ready: assert property (
      $rose(&xfer_ready_o) |-> xfer_done_o) else $error("done not set");
   a_done_clear: assert property (
      xfer_done_clr_i && xfer_ready_o == 8'hff |=> !xfer_done_o)
      else $error("done not cleared");
   a_first_byte: assert property (
      cell_start_i && !cell_busy_o |-> ##3 (tx_valid_o && tx_first_o))
      else $error("first byte late");
   a_byte_holds: assert property (
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
      else $error("byte changed while stalled");
   a_cell_length: assert property (
      tx_valid_o && !tx_first_o |-> tx_last_o == (byte_cnt_r == 6'h34))
      else $error("cell length wrong");
   a_busy_end: assert property (
      tx_valid_o && tx_ready_i && tx_last_o |=> !cell_busy_o)
      else $error("busy after last byte");
endmodule : tic_cell_builder_chk

bind tic_cell_builder tic_cell_builder_chk u_tic_cell_builder_chk (
   .sys_clk_i, .sys_rst_i, .cpu_cs_i, .cpu_wr_i, .cpu_rd_i, .cpu_addr_i,
   .cpu_rdata_o, .cpu_rvalid_o, .xfer_start_i, .xfer_group_i,
   .xfer_ready_o, .xfer_done_o, .xfer_done_clr_i, .cell_start_i,
   .cell_busy_o, .tx_valid_o, .tx_ready_i, .tx_byte_o, .tx_first_o,
   .tx_last_o);

`default_nettype wire

// [test/tic_tx_sink.sv]
`timescale 1ns/10ps
`default_nettype none

module tic_tx_sink
(
   input  wire logic       sys_clk_i,  // core clock
   input  wire logic       sys_rst_i,  // async reset
   input  wire logic       slow_i,     // accept one cycle in four
   input  wire logic       tx_valid_i, // byte valid
   input  wire logic [7:0] tx_byte_i,  // cell byte
   input  wire logic       tx_first_i, // first byte
   output logic            tx_ready_o, // byte accepted
   output logic      [6:0] n_bytes_o   // bytes of last cell
);
   logic [7:0] cell_r [0:63];
   logic [1:0] ph_r;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ph_r       <= 2'h0;
         tx_ready_o <= 1'b0;
         n_bytes_o  <= 7'h00;
      end
      else
      begin
         ph_r       <= ph_r + 2'h1;
         tx_ready_o <= !slow_i || ph_r == 2'h3;
         if (tx_valid_i && tx_ready_o)
         begin
            cell_r[tx_first_i ? 6'h00 : n_bytes_o[5:0]] <= tx_byte_i;
            n_bytes_o <= tx_first_i ? 7'h01 : n_bytes_o + 7'h01;
         end
      end
   end
endmodule : tic_tx_sink

`default_nettype wire

// [test/tic_cell_builder_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module tic_cell_builder_bench;
   import tic_pkg::*;
   logic        sys_clk_i, sys_rst_i, cpu_cs_i, cpu_wr_i, cpu_rd_i;
   logic        cpu_rvalid_o, xfer_start_i, xfer_done_o, xfer_done_clr_i;
   logic        cell_start_i, cell_id_i, cell_busy_o, tx_valid_o;
   logic        tx_ready_i, tx_first_o, tx_last_o, slow;
   logic [10:0] cpu_addr_i;
   logic [15:0] cpu_wdata_i, cpu_rdata_o;
   logic [2:0]  xfer_group_i, cell_group_i;
   logic [4:0]  link_identifier_i;
   logic [7:0]  xfer_ready_o, frame_seq_i, cell_offset_i, stuff_ind_i;
   logic [7:0]  change_ind_i, sync_info_i, tx_byte_o;
   logic [6:0]  n_bytes;
   logic [7:0]  exp_b [1:53];
   int          n_fail = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          grp [2] = '{5, 0};

   tic_cell_builder u_tic_cell_builder (.sys_clk_i, .sys_rst_i, .cpu_cs_i,
      .cpu_wr_i, .cpu_rd_i, .cpu_addr_i, .cpu_wdata_i, .cpu_rdata_o,
      .cpu_rvalid_o, .xfer_start_i, .xfer_group_i, .xfer_ready_o,
      .xfer_done_o, .xfer_done_clr_i, .cell_start_i, .cell_group_i,
      .cell_id_i, .link_identifier_i, .frame_seq_i, .cell_offset_i,
      .stuff_ind_i, .change_ind_i, .sync_info_i, .cell_busy_o,
      .tx_valid_o, .tx_ready_i, .tx_byte_o, .tx_first_o, .tx_last_o);

   tic_tx_sink u_tic_tx_sink (.sys_clk_i, .sys_rst_i, .slow_i(slow),
      .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
      .tx_first_i(tx_first_o), .tx_ready_o(tx_ready_i),
      .n_bytes_o(n_bytes));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         test_done();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // template contents as software must lay them out
   function automatic logic [15:0] tpl(input int g, input int w);
      case (w)
         0: return 16'h0000;
         1: return 16'h0b00;
         2: return {8'(1 + 2 * (g % 2)), 8'h5a};
         24: return {8'h6a, 8'(g + 31)};
         default: return {8'(w * 37 + g), 8'(w * 11 + g * 53)};
      endcase
   endfunction : tpl

   task automatic cpu_wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      cpu_cs_i    <= 1'b1;
      cpu_wr_i    <= 1'b1;
      cpu_addr_i  <= a;
      cpu_wdata_i <= d;
      @(posedge sys_clk_i);
      cpu_cs_i <= 1'b0;
      cpu_wr_i <= 1'b0;
   endtask : cpu_wr

   task automatic rd_chk(input logic [10:0] a, input logic [15:0] exp);
      @(posedge sys_clk_i);
      cpu_cs_i   <= 1'b1;
      cpu_rd_i   <= 1'b1;
      cpu_addr_i <= a;
      @(posedge sys_clk_i);
      cpu_cs_i <= 1'b0;
      cpu_rd_i <= 1'b0;
      #1;
      chk(cpu_rvalid_o, 1'b1);
      chk(cpu_rdata_o, exp);
   endtask : rd_chk

   task automatic copy(input logic [2:0] g);
      int n;
      @(posedge sys_clk_i);
      xfer_group_i <= g;
      xfer_start_i <= 1'b1;
      @(posedge sys_clk_i);
      xfer_start_i <= 1'b0;
      n = 0;
      #1;
      chk(xfer_ready_o, 8'(~(8'h01 << g)));
      while (xfer_ready_o[g] !== 1'b1 && n < 100)
      begin
         @(posedge sys_clk_i);
         xfer_start_i <= (n == 4);
         xfer_group_i <= ~g;
         xfer_done_clr_i <= (n == 31);
         cpu_cs_i        <= (n == 8 && g == 3'h0);
         cpu_rd_i        <= (n == 8 && g == 3'h0);
         cpu_addr_i      <= TIC_TPL_BASE;
         n++;
         #1;
      end
      chk(16'(n), g ? 16'h0021 : 16'h0022);
      chk(xfer_ready_o, 8'hff);
      chk(xfer_done_o, 1'b1);
      @(posedge sys_clk_i);
      xfer_done_clr_i <= 1'b1;
      @(posedge sys_clk_i);
      xfer_done_clr_i <= 1'b0;
      #1;
      chk(xfer_done_o, 1'b0);
   endtask : copy

   task automatic send_cell(input int g, input logic [7:0] s);
      logic [15:0] w;
      logic [7:0]  h;
      logic [9:0]  c;
      int          n;
      @(posedge sys_clk_i);
      cell_group_i      <= 3'(g);
      cell_start_i      <= 1'b1;
      cell_id_i         <= s[0];
      link_identifier_i <= s[6:2];
      frame_seq_i       <= s;
      cell_offset_i     <= s + 8'h01;
      stuff_ind_i       <= ~s;
      change_ind_i      <= s + 8'h10;
      sync_info_i       <= s + 8'h20;
      @(posedge sys_clk_i);
      cell_start_i <= 1'b0;
      n = 0;
      #1;
      while (cell_busy_o !== 1'b0 && n < 1000)
      begin
         @(posedge sys_clk_i);
         n++;
         #1;
      end
      for (int b = 1; b <= 53; b++)
      begin
         w = tpl(g, (b - 1) / 2);
         exp_b[b] = b[0] ? w[7:0] : w[15:8];
      end
      exp_b[7] = {cell_id_i, exp_b[7][6:5], link_identifier_i};
      exp_b[8] = frame_seq_i;
      exp_b[9] = cell_offset_i;
      exp_b[10] = stuff_ind_i;
      exp_b[11] = change_ind_i;
      exp_b[14] = sync_info_i;
      exp_b[52][1:0] = 2'b00;
      exp_b[53] = 8'h00;
      h = 8'h00;
      c = 10'h000;
      for (int b = 1; b <= 53; b++)
         for (int i = 7; i >= 0; i--)
         begin
            if (b <= 4)
               h = {h[6:0], 1'b0} ^ ((h[7] ^ exp_b[b][i]) ? 8'h07 : 8'h00);
            if (b >= 6)
               c = {c[8:0], exp_b[b][i]} ^ (c[9] ? 10'h233 : 10'h000);
         end
      exp_b[5] = h ^ 8'h55;
      exp_b[52][1:0] = c[9:8];
      exp_b[53] = c[7:0];
      chk(n_bytes, 7'h35);
      for (int b = 1; b <= 53; b++)
         chk(u_tic_tx_sink.cell_r[b - 1], exp_b[b]);
   endtask : send_cell

   initial
   begin
      {cpu_cs_i, cpu_wr_i, cpu_rd_i, xfer_start_i, xfer_done_clr_i} = '0;
      {cell_start_i, cell_id_i, slow, cpu_addr_i, cpu_wdata_i} = '0;
      {xfer_group_i, cell_group_i, link_identifier_i, frame_seq_i} = '0;
      {cell_offset_i, stuff_ind_i, change_ind_i, sync_info_i} = '0;
      sys_rst_i = 1'b1;
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(xfer_ready_o, 8'hff);
      chk({xfer_done_o, cell_busy_o, tx_valid_o}, 3'b000);
      $display("test reset done");
      for (int k = 0; k < 2; k++)
         for (int w = 0; w < 32; w++)
            cpu_wr(TIC_TPL_BASE + 11'(grp[k] * 32 + w), tpl(grp[k], w));
      cpu_wr(11'h600, 16'hbeef);
      rd_chk(11'h600, 16'h0000);
      rd_chk(11'h4ff, 16'h0000);
      $display("test template write done");
      copy(3'h5);
      copy(3'h0);
      $display("test transfer done");
      send_cell(5, 8'h31);
      slow <= 1'b1;
      send_cell(0, 8'hc4);
      $display("test cell send done");
      for (int k = 0; k < 2; k++)
         for (int w = 0; w < 32; w++)
            rd_chk(TIC_TPL_BASE + 11'(grp[k] * 32 + w), tpl(grp[k], w));
      $display("test template readback done");
      test_done();
   end
endmodule : tic_cell_builder_bench

`default_nettype wire
